/* include/uart_host_pkg.sv */
// constants and types shared by the dual uart host port and its helpers
// assumes a single 10 mhz core clock and bus pins sampled on that clock
`default_nettype none

package uart_host_pkg;
  // register offsets within a channel
  localparam logic [2:0] A_DATA    = 3'h0;
  localparam logic [2:0] A_IER     = 3'h1;
  localparam logic [2:0] A_FCR     = 3'h2;
  localparam logic [2:0] A_LCR     = 3'h3;
  localparam logic [2:0] A_MCR     = 3'h4;
  localparam logic [2:0] A_LSR     = 3'h5;
  localparam logic [2:0] A_FEAT    = 3'h6;
  localparam logic [2:0] A_SCRATCH = 3'h7;
  // divisor bank, visible while the latch bit of lcr is set
  localparam logic [2:0] A_DIV_LOW  = 3'h0;
  localparam logic [2:0] A_DIV_HIGH = 3'h1;
  localparam logic [2:0] A_DIV_FRAC = 3'h2;

  // field positions
  localparam int LCR_DLAB_BIT      = 7;
  localparam int MCR_RTS_BIT       = 1;
  localparam int MCR_PRESCALE4_BIT = 7;
  localparam int FCR_RX_CLR_BIT    = 1;
  localparam int FCR_TX_CLR_BIT    = 2;
  localparam int FEAT_AUTO_DIR_BIT = 3;
  localparam int FEAT_SAMPLE8_BIT  = 6;

  // reset values
  localparam logic [7:0] LCR_RESET      = 8'h00;
  localparam logic [7:0] IER_RESET      = 8'h00;
  localparam logic [7:0] MCR_RESET      = 8'h00;
  localparam logic [7:0] FEAT_RESET     = 8'h00;
  localparam logic [7:0] SCRATCH_RESET  = 8'hff;
  localparam logic [7:0] DIV_LOW_RESET  = 8'h01;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic [3:0] DIV_FRAC_RESET = 4'h0;
  localparam logic [7:0] ISR_IDLE       = 8'h01;

  // identity values, both arbitrary
  localparam logic [7:0] DEVICE_CODE   = 8'h5c;
  localparam logic [7:0] REVISION_CODE = 8'h03;

  // fifo geometry
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W      = 7;

  // timing: reset pulse floor and its cycle count at the core rate
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_MIN_NS  = 40;
  localparam int RESET_CYCLES  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // oversampling counts, last index of a bit period and its middle
  localparam logic [3:0] OS16_LAST = 4'hf;
  localparam logic [3:0] OS8_LAST  = 4'h7;
  localparam logic [3:0] OS16_MID  = 4'h7;
  localparam logic [3:0] OS8_MID   = 4'h3;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
endpackage

`default_nettype wire

/* include/byte_fifo_if.sv */
// link between a channel and one of its byte fifos
// assumes the owner registers state on core_clk
`default_nettype none

interface byte_fifo_if;
  logic       push;
  logic [7:0] push_data;
  logic       pop;
  logic [7:0] pop_data;
  logic       clear;
  logic       full;
  logic       empty;
  modport owner (input push, push_data, pop, clear, output pop_data, full, empty);
  modport user  (output push, push_data, pop, clear, input pop_data, full, empty);
endinterface

`default_nettype wire

/* include/baud_if.sv */
// link between a channel and its baud tick generator
// assumes ticks are single core_clk pulses
`default_nettype none

interface baud_if;
  logic [15:0] divisor;
  logic [3:0]  fraction;
  logic        prescale4;
  logic        sample8;
  logic        os_tick;
  logic        bit_tick;
  modport gen  (input divisor, fraction, prescale4, sample8, output os_tick, bit_tick);
  modport user (output divisor, fraction, prescale4, sample8, input os_tick, bit_tick);
endinterface

`default_nettype wire

/* hw/byte_fifo.sv */
// 64 entry byte fifo for one direction of one channel
// assumes the user never pushes when full nor pops when empty
`default_nettype none

module byte_fifo (
  input  wire logic     core_clk,
  input  wire logic     reset_n,
  byte_fifo_if.owner    port
);
  typedef struct packed {
    logic [uart_host_pkg::FIFO_DEPTH-1:0][7:0] mem;
    logic [uart_host_pkg::PTR_W-1:0]           wptr;
    logic [uart_host_pkg::PTR_W-1:0]           rptr;
  } fifo_state_type;

  fifo_state_type q;
  fifo_state_type d;
  logic [uart_host_pkg::PTR_W-1:0] level;

  // level from pointer difference, one spare bit tells full from empty
  assign level         = q.wptr - q.rptr;
  assign port.full     = (level == 7'(uart_host_pkg::FIFO_DEPTH));
  assign port.empty    = (level == 7'h00);
  assign port.pop_data = q.mem[q.rptr[5:0]];

  // next state
  always_comb begin
    d = q;
    if (port.push && !port.full) begin
      d.mem[q.wptr[5:0]] = port.push_data;
      d.wptr             = q.wptr + 7'h01;
    end
    if (port.pop && !port.empty) begin
      d.rptr = q.rptr + 7'h01;
    end
    // clear drops content but keeps memory, cheaper than wiping it
    if (port.clear) begin
      d.wptr = 7'h00;
      d.rptr = 7'h00;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q.mem  <= '0;
      q.wptr <= 7'h00;
      q.rptr <= 7'h00;
    end else begin
      q <= d;
    end
  end
endmodule // byte_fifo

`default_nettype wire

/* hw/baud_tick_gen.sv */
// fractional baud generator with prescaler and 8x or 16x oversampling
// assumes divisor of zero means the channel is stopped
`default_nettype none

module baud_tick_gen (
  input  wire logic core_clk,
  input  wire logic reset_n,
  baud_if.gen       port
);
  typedef struct packed {
    logic [1:0]  pre_cnt;
    logic [15:0] div_cnt;
    logic [3:0]  frac_acc;
    logic [3:0]  os_cnt;
    logic        os_tick;
    logic        bit_tick;
  } baud_state_type;

  baud_state_type q;
  baud_state_type d;
  logic           step;
  logic [4:0]     acc_sum;
  logic [3:0]     os_last;

  assign port.os_tick  = q.os_tick;
  assign port.bit_tick = q.bit_tick;
  assign step    = !port.prescale4 || (q.pre_cnt == 2'h3);
  assign acc_sum = {1'b0, q.frac_acc} + {1'b0, port.fraction};
  assign os_last = port.sample8 ? uart_host_pkg::OS8_LAST
                                : uart_host_pkg::OS16_LAST;

  // fraction carry stretches one period in sixteen per fraction step
  always_comb begin
    d          = q;
    d.os_tick  = 1'b0;
    d.bit_tick = 1'b0;
    d.pre_cnt  = q.pre_cnt + 2'h1;
    if (port.divisor == 16'h0000) begin
      d.div_cnt = 16'h0000;
      d.os_cnt  = 4'h0;
    end else if (step) begin
      if (q.div_cnt == 16'h0000) begin
        d.frac_acc = acc_sum[3:0];
        d.div_cnt  = port.divisor - 16'h0001 + {15'h0000, acc_sum[4]};
        d.os_tick  = 1'b1;
        if (q.os_cnt >= os_last) begin
          d.os_cnt   = 4'h0;
          d.bit_tick = 1'b1;
        end else begin
          d.os_cnt = q.os_cnt + 4'h1;
        end
      end else begin
        d.div_cnt = q.div_cnt - 16'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // baud_tick_gen

`default_nettype wire

/* hw/dual_uart_host_port.sv */
// host bus front end and serial engines for two uart channels
// assumes bus strobes are synchronous to core_clk and wider than one cycle
//
// What this block does
// - reset clears most registers; scratch ff, divisor 1, tx and direction high
// - in reset tx high, rx ignored
// - eight data bits, three address bits
// - bus cycles framed by select and strobes
// - only the addressed channel reads or writes
// - select high ignores; pick high is channel a
// - zero divisor bytes, high byte reads device code
// - zero divisor bytes, low byte reads revision
// - auto direction: receive after last stop bit
// - auto direction: loading data selects transmit
// - auto direction off at reset, feature bit 3
// - direction high receive, low transmit
// - per channel registers and 64 byte fifos
// - prescaler divides by one or four
// - oversampling of 8 or 16 per bit
`default_nettype none

module dual_uart_host_port (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       chip_select_n,
  input  wire logic       channel_pick,
  input  wire logic [2:0] reg_addr,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            bus_data_oe,
  input  wire logic [1:0] serial_rx,
  output logic      [1:0] serial_tx,
  output logic      [1:0] direction
);
  typedef struct packed {
    logic [7:0]                  lcr;
    logic [7:0]                  ier;
    logic [7:0]                  mcr;
    logic [7:0]                  feat;
    logic [7:0]                  scratch;
    logic [7:0]                  div_low;
    logic [7:0]                  div_high;
    logic [3:0]                  div_frac;
    logic                        overrun;
    uart_host_pkg::tx_state_type tx_state;
    logic [7:0]                  tx_shift;
    logic [2:0]                  tx_bits;
    logic                        tx_line;
    logic                        dir;
    uart_host_pkg::rx_state_type rx_state;
    logic [3:0]                  rx_cnt;
    logic [7:0]                  rx_shift;
    logic [2:0]                  rx_bits;
  } chan_type;

  typedef struct packed {
    chan_type [1:0] ch;
    logic           wr_prev;
    logic           rd_prev;
    logic           wr_hit;
    logic           rd_hit;
    logic           wr_chan;
    logic           rd_chan;
    logic [2:0]     wr_addr;
    logic [2:0]     rd_addr;
    logic [7:0]     wr_data;
    logic [7:0]     data_out;
    logic           data_oe;
  } top_state_type;

  top_state_type   q;
  top_state_type   d;
  top_state_type   reset_state;
  logic [1:0]      tx_push;
  logic [1:0]      tx_pop;
  logic [1:0]      tx_clear;
  logic [1:0]      tx_empty;
  logic [1:0]      tx_full;
  logic [1:0][7:0] tx_head;
  logic [1:0]      rx_push;
  logic [1:0][7:0] rx_push_data;
  logic [1:0]      rx_pop;
  logic [1:0]      rx_clear;
  logic [1:0]      rx_empty;
  logic [1:0]      rx_full;
  logic [1:0][7:0] rx_head;
  logic [1:0]      os_tick;
  logic [1:0]      bit_tick;

  // outputs straight from state flops
  assign bus_data_out = q.data_out;
  assign bus_data_oe  = q.data_oe;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      serial_tx[i] = q.ch[i].tx_line;
      direction[i] = q.ch[i].dir;
    end
  end

  // per channel fifos and baud generator, fully independent
  for (genvar g = 0; g < 2; g++) begin : gen_chan
    byte_fifo_if tx_link ();
    byte_fifo_if rx_link ();
    baud_if      baud_link ();

    assign tx_link.push       = tx_push[g];
    assign tx_link.push_data  = q.wr_data;
    assign tx_link.pop        = tx_pop[g];
    assign tx_link.clear      = tx_clear[g];
    assign tx_empty[g]        = tx_link.empty;
    assign tx_full[g]         = tx_link.full;
    assign tx_head[g]         = tx_link.pop_data;
    assign rx_link.push       = rx_push[g];
    assign rx_link.push_data  = rx_push_data[g];
    assign rx_link.pop        = rx_pop[g];
    assign rx_link.clear      = rx_clear[g];
    assign rx_empty[g]        = rx_link.empty;
    assign rx_full[g]         = rx_link.full;
    assign rx_head[g]         = rx_link.pop_data;
    assign baud_link.divisor   = {q.ch[g].div_high, q.ch[g].div_low};
    assign baud_link.fraction  = q.ch[g].div_frac;
    assign baud_link.prescale4 = q.ch[g].mcr[uart_host_pkg::MCR_PRESCALE4_BIT];
    assign baud_link.sample8   = q.ch[g].feat[uart_host_pkg::FEAT_SAMPLE8_BIT];
    assign os_tick[g]          = baud_link.os_tick;
    assign bit_tick[g]         = baud_link.bit_tick;

    byte_fifo u_tx_fifo (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .port     (tx_link.owner)
    );
    byte_fifo u_rx_fifo (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .port     (rx_link.owner)
    );
    baud_tick_gen u_baud (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .port     (baud_link.gen)
    );
  end

  // register read view of one channel
  function automatic logic [7:0] read_view(input chan_type c, input logic [2:0] a,
                                           input logic [7:0] rx_data, input logic rx_ne,
                                           input logic tx_e);
    logic dlab;
    logic ident;
    logic temt;
    dlab  = c.lcr[uart_host_pkg::LCR_DLAB_BIT];
    ident = (c.div_low == 8'h00) && (c.div_high == 8'h00);
    temt  = tx_e && (c.tx_state == uart_host_pkg::TX_IDLE);
    read_view = 8'h00;
    case (a)
      uart_host_pkg::A_DATA: begin
        if (dlab) begin
          read_view = ident ? uart_host_pkg::REVISION_CODE : c.div_low;
        end else begin
          read_view = rx_data;
        end
      end
      uart_host_pkg::A_IER: begin
        if (dlab) begin
          read_view = ident ? uart_host_pkg::DEVICE_CODE : c.div_high;
        end else begin
          read_view = c.ier;
        end
      end
      uart_host_pkg::A_FCR: read_view = dlab ? {4'h0, c.div_frac} : uart_host_pkg::ISR_IDLE;
      uart_host_pkg::A_LCR: read_view = c.lcr;
      uart_host_pkg::A_MCR: read_view = c.mcr;
      uart_host_pkg::A_LSR: read_view = {1'b0, temt, tx_e, 3'h0, c.overrun, rx_ne};
      uart_host_pkg::A_FEAT: read_view = c.feat;
      uart_host_pkg::A_SCRATCH: read_view = c.scratch;
      default: read_view = 8'h00;
    endcase
  endfunction

  // reset image of the whole state
  always_comb begin
    reset_state = '0;
    for (int i = 0; i < 2; i++) begin
      reset_state.ch[i].lcr      = uart_host_pkg::LCR_RESET;
      reset_state.ch[i].ier      = uart_host_pkg::IER_RESET;
      reset_state.ch[i].mcr      = uart_host_pkg::MCR_RESET;
      reset_state.ch[i].feat     = uart_host_pkg::FEAT_RESET;
      reset_state.ch[i].scratch  = uart_host_pkg::SCRATCH_RESET;
      reset_state.ch[i].div_low  = uart_host_pkg::DIV_LOW_RESET;
      reset_state.ch[i].div_high = uart_host_pkg::DIV_HIGH_RESET;
      reset_state.ch[i].div_frac = uart_host_pkg::DIV_FRAC_RESET;
      reset_state.ch[i].tx_line  = 1'b1;
      reset_state.ch[i].dir      = 1'b1;
    end
    reset_state.wr_prev = 1'b1;
    reset_state.rd_prev = 1'b1;
  end

  // bus front end, then both serial engines
  always_comb begin
    logic       sel_chan;
    logic       wr_done;
    logic       rd_done;
    logic       dlab;
    logic       auto_dir;
    logic [3:0] os_last;
    logic [3:0] os_mid;
    logic [2:0] last_bit;
    d            = q;
    sel_chan     = !channel_pick; // pick high is index 0, channel a
    tx_push      = 2'b00;
    tx_pop       = 2'b00;
    tx_clear     = 2'b00;
    rx_push      = 2'b00;
    rx_pop       = 2'b00;
    rx_clear     = 2'b00;
    rx_push_data = '0;
    dlab         = 1'b0;
    auto_dir     = 1'b0;
    os_last      = uart_host_pkg::OS16_LAST;
    os_mid       = uart_host_pkg::OS16_MID;
    last_bit     = 3'h7;
    d.wr_prev    = write_strobe_n;
    d.rd_prev    = read_strobe_n;
    wr_done      = !q.wr_prev && write_strobe_n;
    rd_done      = !q.rd_prev && read_strobe_n;

    // capture the cycle while its strobe is low
    if (!write_strobe_n) begin
      d.wr_hit  = !chip_select_n;
      d.wr_chan = sel_chan;
      d.wr_addr = reg_addr;
      d.wr_data = bus_data_in;
    end
    if (!read_strobe_n) begin
      d.rd_hit  = !chip_select_n;
      d.rd_chan = sel_chan;
      d.rd_addr = reg_addr;
    end

    // read data driven only for the addressed channel
    d.data_oe  = !read_strobe_n && !chip_select_n;
    d.data_out = 8'h00;
    for (int i = 0; i < 2; i++) begin
      if (d.data_oe && (sel_chan == 1'(i))) begin
        d.data_out = read_view(q.ch[i], reg_addr, rx_head[i], !rx_empty[i], tx_empty[i]);
      end
    end

    for (int i = 0; i < 2; i++) begin
      dlab     = q.ch[i].lcr[uart_host_pkg::LCR_DLAB_BIT];
      auto_dir = q.ch[i].feat[uart_host_pkg::FEAT_AUTO_DIR_BIT];
      os_last  = q.ch[i].feat[uart_host_pkg::FEAT_SAMPLE8_BIT] ? uart_host_pkg::OS8_LAST
                                                                : uart_host_pkg::OS16_LAST;
      os_mid   = q.ch[i].feat[uart_host_pkg::FEAT_SAMPLE8_BIT] ? uart_host_pkg::OS8_MID
                                                                : uart_host_pkg::OS16_MID;
      last_bit = 3'h4 + {1'b0, q.ch[i].lcr[1:0]};

      // register writes land on the strobe's rising edge
      if (wr_done && q.wr_hit && (q.wr_chan == 1'(i))) begin
        case (q.wr_addr)
          uart_host_pkg::A_DATA: begin
            if (dlab) begin
              d.ch[i].div_low = q.wr_data;
            end else begin
              tx_push[i] = !tx_full[i];
            end
          end
          uart_host_pkg::A_IER: begin
            if (dlab) begin
              d.ch[i].div_high = q.wr_data;
            end else begin
              d.ch[i].ier = q.wr_data;
            end
          end
          uart_host_pkg::A_FCR: begin
            if (dlab) begin
              d.ch[i].div_frac = q.wr_data[3:0];
            end else begin
              rx_clear[i] = q.wr_data[uart_host_pkg::FCR_RX_CLR_BIT];
              tx_clear[i] = q.wr_data[uart_host_pkg::FCR_TX_CLR_BIT];
            end
          end
          uart_host_pkg::A_LCR:     d.ch[i].lcr     = q.wr_data;
          uart_host_pkg::A_MCR:     d.ch[i].mcr     = q.wr_data;
          uart_host_pkg::A_FEAT:    d.ch[i].feat    = q.wr_data;
          uart_host_pkg::A_SCRATCH: d.ch[i].scratch = q.wr_data;
          default: ;
        endcase
      end

      // read side effects: data read pops, status read clears overrun
      if (rd_done && q.rd_hit && (q.rd_chan == 1'(i)) && !dlab) begin
        rx_pop[i] = (q.rd_addr == uart_host_pkg::A_DATA);
        if (q.rd_addr == uart_host_pkg::A_LSR) begin
          d.ch[i].overrun = 1'b0;
        end
      end

      // transmitter, paced by bit ticks; line idles high
      case (q.ch[i].tx_state)
        uart_host_pkg::TX_IDLE: begin
          if (bit_tick[i] && !tx_empty[i]) begin
            tx_pop[i]         = 1'b1;
            d.ch[i].tx_shift  = tx_head[i];
            d.ch[i].tx_line   = 1'b0;
            d.ch[i].tx_state  = uart_host_pkg::TX_START;
          end
        end
        uart_host_pkg::TX_START: begin
          if (bit_tick[i]) begin
            d.ch[i].tx_line  = q.ch[i].tx_shift[0];
            d.ch[i].tx_shift = {1'b0, q.ch[i].tx_shift[7:1]};
            d.ch[i].tx_bits  = 3'h0;
            d.ch[i].tx_state = uart_host_pkg::TX_DATA;
          end
        end
        uart_host_pkg::TX_DATA: begin
          if (bit_tick[i]) begin
            if (q.ch[i].tx_bits == last_bit) begin
              d.ch[i].tx_line  = 1'b1;
              d.ch[i].tx_state = uart_host_pkg::TX_STOP;
            end else begin
              d.ch[i].tx_line  = q.ch[i].tx_shift[0];
              d.ch[i].tx_shift = {1'b0, q.ch[i].tx_shift[7:1]};
              d.ch[i].tx_bits  = q.ch[i].tx_bits + 3'h1;
            end
          end
        end
        uart_host_pkg::TX_STOP: begin
          if (bit_tick[i]) begin
            d.ch[i].tx_state = uart_host_pkg::TX_IDLE;
          end
        end
        default: d.ch[i].tx_state = uart_host_pkg::TX_IDLE;
      endcase

      // direction: a load wins over the idle test in the same cycle
      if (!auto_dir) begin
        d.ch[i].dir = !q.ch[i].mcr[uart_host_pkg::MCR_RTS_BIT];
      end else if (tx_push[i]) begin
        d.ch[i].dir = 1'b0;
      end else if ((q.ch[i].tx_state == uart_host_pkg::TX_IDLE) && tx_empty[i]) begin
        d.ch[i].dir = 1'b1;
      end

      // receiver, start checked at mid bit, data sampled each bit after
      rx_push_data[i] = q.ch[i].rx_shift >> (2'h3 - q.ch[i].lcr[1:0]);
      case (q.ch[i].rx_state)
        uart_host_pkg::RX_IDLE: begin
          if (!serial_rx[i]) begin
            d.ch[i].rx_cnt   = 4'h0;
            d.ch[i].rx_state = uart_host_pkg::RX_START;
          end
        end
        uart_host_pkg::RX_START: begin
          if (os_tick[i]) begin
            d.ch[i].rx_cnt = q.ch[i].rx_cnt + 4'h1;
            if (q.ch[i].rx_cnt == os_mid) begin
              d.ch[i].rx_cnt   = 4'h0;
              d.ch[i].rx_bits  = 3'h0;
              d.ch[i].rx_state = serial_rx[i] ? uart_host_pkg::RX_IDLE
                                              : uart_host_pkg::RX_DATA;
            end
          end
        end
        uart_host_pkg::RX_DATA: begin
          if (os_tick[i]) begin
            d.ch[i].rx_cnt = q.ch[i].rx_cnt + 4'h1;
            if (q.ch[i].rx_cnt == os_last) begin
              d.ch[i].rx_cnt   = 4'h0;
              d.ch[i].rx_shift = {serial_rx[i], q.ch[i].rx_shift[7:1]};
              d.ch[i].rx_bits  = q.ch[i].rx_bits + 3'h1;
              if (q.ch[i].rx_bits == last_bit) begin
                d.ch[i].rx_state = uart_host_pkg::RX_STOP;
              end
            end
          end
        end
        uart_host_pkg::RX_STOP: begin
          if (os_tick[i]) begin
            d.ch[i].rx_cnt = q.ch[i].rx_cnt + 4'h1;
            if (q.ch[i].rx_cnt == os_last) begin
              d.ch[i].rx_state = uart_host_pkg::RX_IDLE;
              // a framing error drops the byte; full fifo flags overrun
              if (serial_rx[i]) begin
                rx_push[i] = !rx_full[i];
                if (rx_full[i]) begin
                  d.ch[i].overrun = 1'b1; // set beats a same cycle clear
                end
              end
            end
          end
        end
        default: d.ch[i].rx_state = uart_host_pkg::RX_IDLE;
      endcase
    end
  end

  // state register; one cycle of reset covers the 40 ns floor
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= reset_state;
    end else begin
      q <= d;
    end
  end
endmodule // dual_uart_host_port

`default_nettype wire

/* bench/uart_port_properties.sv */
// pin level assertions for the dual uart host port
// assumes bus pins are sampled on core_clk, as the design does
`default_nettype none

module uart_port_checker (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       chip_select_n,
  input wire logic       channel_pick,
  input wire logic [2:0] reg_addr,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [7:0] bus_data_in,
  input wire logic [7:0] bus_data_out,
  input wire logic       bus_data_oe,
  input wire logic [1:0] serial_rx,
  input wire logic [1:0] serial_tx,
  input wire logic [1:0] direction
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // idle levels at the first edge out of reset
  chk_tx_reset_idle: assert property ($rose(reset_n) |-> serial_tx == 2'b11)
    else $error("tx not idle after reset");
  chk_dir_reset_rx: assert property ($rose(reset_n) |-> direction == 2'b11)
    else $error("direction not receive after reset");
  chk_oe_reset_off: assert property ($rose(reset_n) |-> !bus_data_oe)
    else $error("bus driven after reset");
  // read answer a cycle after the strobe is seen
  chk_read_answer: assert property (!read_strobe_n && !chip_select_n |=> bus_data_oe)
    else $error("read not answered");
  chk_deselect_quiet: assert property (chip_select_n |=> !bus_data_oe)
    else $error("bus driven while deselected");
  chk_idle_no_drive: assert property (read_strobe_n |=> !bus_data_oe)
    else $error("bus driven without read");
  chk_out_zero_idle: assert property (!bus_data_oe |-> bus_data_out == 8'h00)
    else $error("data out not zero while idle");
  chk_oe_from_strobe: assert property ($rose(bus_data_oe) |-> $past(read_strobe_n) == 1'b0)
    else $error("drive began without strobe");
endmodule // uart_port_checker

bind dual_uart_host_port uart_port_checker u_chk (.core_clk, .reset_n, .chip_select_n,
  .channel_pick, .reg_addr, .read_strobe_n, .write_strobe_n, .bus_data_in, .bus_data_out,
  .bus_data_oe, .serial_rx, .serial_tx, .direction);

`default_nettype wire

/* bench/line_echo.sv */
// far side: each channel's transceiver hears its own line
// assumes tx idles high, so the echoed line idles high too
`default_nettype none

module line_echo (
  input  wire logic [1:0] serial_tx,
  output logic      [1:0] serial_rx
);
  timeunit 1ns;
  timeprecision 1ns;
  // shared pair, so whatever we send comes straight back
  assign serial_rx = serial_tx;
endmodule // line_echo

`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the dual uart host port
// assumes the checker binds itself and line_echo closes the serial loop
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 0, reset_n = 0, chip_select_n = 1, channel_pick = 1;
  logic       read_strobe_n = 1, write_strobe_n = 1, bus_data_oe;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] bus_data_in = 8'h00, bus_data_out;
  logic [1:0] serial_rx, serial_tx, direction;
  int         n_mismatch = 0, comparisons = 0, cyc = 0, n;

  dual_uart_host_port u_dut (.core_clk, .reset_n, .chip_select_n, .channel_pick, .reg_addr,
    .read_strobe_n, .write_strobe_n, .bus_data_in, .bus_data_out, .bus_data_oe,
    .serial_rx, .serial_tx, .direction);
  line_echo u_far (.serial_tx, .serial_rx);

  initial forever #50 core_clk = ~core_clk;

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // a hung wait ends the run instead of spinning
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write; s=1 leaves the chip deselected
  task automatic wr(input logic c, input logic [2:0] a, input logic [7:0] d, input logic s = 0);
    @(posedge core_clk);
    chip_select_n <= s;
    channel_pick <= c;
    reg_addr <= a;
    bus_data_in <= d;
    write_strobe_n <= 1'b0;
    @(posedge core_clk);
    write_strobe_n <= 1'b1;
    @(posedge core_clk);
    chip_select_n <= 1'b1;
  endtask

  // one read, data judged while the strobe is still low
  task automatic rd(input logic c, input logic [2:0] a, input logic [7:0] e);
    @(posedge core_clk);
    chip_select_n <= 1'b0;
    channel_pick <= c;
    reg_addr <= a;
    read_strobe_n <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(bus_data_out, e);
    @(posedge core_clk);
    read_strobe_n <= 1'b1;
    chip_select_n <= 1'b1;
  endtask

  task automatic t_reset();
    for (int c = 0; c < 2; c++) begin
      rd(c[0], 3'h7, 8'hff);
      rd(c[0], 3'h3, 8'h00);
      rd(c[0], 3'h6, 8'h00);
    end
  endtask

  task automatic t_ident();
    for (int c = 0; c < 2; c++) begin
      wr(c[0], 3'h3, 8'h80);
      wr(c[0], 3'h0, 8'h00);
      wr(c[0], 3'h1, 8'h00);
      rd(c[0], 3'h1, uart_host_pkg::DEVICE_CODE);
      rd(c[0], 3'h0, uart_host_pkg::REVISION_CODE);
      wr(c[0], 3'h0, 8'h01);
      rd(c[0], 3'h0, 8'h01);
      wr(c[0], 3'h3, 8'h03);
    end
  endtask

  task automatic t_select();
    wr(1, 3'h7, 8'h5a);
    wr(0, 3'h7, 8'ha5);
    wr(1, 3'h7, 8'h00, 1);
    rd(1, 3'h7, 8'h5a);
    rd(0, 3'h7, 8'ha5);
  endtask

  task automatic t_auto_dir();
    wr(1, 3'h4, 8'h02);
    // the new mcr value reaches the pin one cycle after the write lands
    repeat (2) @(negedge core_clk);
    chk({6'h0, direction}, 8'h02);
    wr(1, 3'h4, 8'h00);
    wr(1, 3'h6, 8'h08);
    wr(1, 3'h0, 8'h3c);
    repeat (2) @(negedge core_clk);
    chk({6'h0, direction}, 8'h02);
    // ten bits of sixteen samples go out before the turn-round
    for (n = 0; n < 400 && direction[0] !== 1'b1; n++) @(negedge core_clk);
    chk({7'h0, n >= 150 && n < 300}, 8'h01);
    repeat (40) @(negedge core_clk);
    rd(1, 3'h0, 8'h3c);
  endtask

  // channel b at prescale four and 8x: a 32 cycle bit, ten bits a frame
  task automatic t_rate();
    wr(0, 3'h4, 8'h80);
    wr(0, 3'h6, 8'h48);
    wr(0, 3'h0, 8'hc3);
    repeat (2) @(negedge core_clk);
    chk({6'h0, direction}, 8'h01);
    for (n = 0; n < 400 && direction[1] !== 1'b1; n++) @(negedge core_clk);
    chk({7'h0, n >= 300 && n < 360}, 8'h01);
    rd(0, 3'h0, 8'hc3);
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    t_ident();
    t_select();
    t_auto_dir();
    t_rate();
    finish_test();
  end
endmodule // tb

`default_nettype wire
